// file: src/pin_irq_params.svh
// Purpose: register indices, field positions, reset values and pin maps
// Assumes: included by bare name from every design file that needs it
// Notes: byte address on the bus is four times the register index
`ifndef PIN_IRQ_PARAMS_SVH
`define PIN_IRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_ALT_CTRL0 6'h30
`define IDX_ALT_CTRL1 6'h31
`define IDX_MCU_CTRL 6'h35
`define IDX_TIMER_FLAGS 6'h38
`define IDX_TIMER_MASK 6'h39
`define IDX_GIRQ_FLAGS 6'h3A
`define IDX_GIRQ_MASK 6'h3B

// ----------------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------------
`define MCU_CTRL_WMASK 8'h7B
`define TIMER_MASK_WMASK 8'h06
`define GIRQ_MASK_WMASK 8'h70
`define ALT_CTRL0_WMASK 8'h3F
`define ALT_CTRL1_WMASK 8'h77
`define REG_RESET 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_PULLUP_KILL 6
`define BIT_SLEEP_ARM 5
`define BIT_SLEEP_MODE_HI 4
`define BIT_SLEEP_MODE_LO 3
`define BIT_EXT_SENSE_HI 1
`define BIT_EXT_SENSE_LO 0
`define BIT_T1_OVF 2
`define BIT_T0_OVF 1
`define BIT_EXT_EN 6
`define BIT_PC_GRP_HI 5
`define BIT_PC_GRP_LO 4
`define BIT_EXT_FLAG 6
`define BIT_PC_FLAG 5
// alt control 0: vref, comparator off, wire mode lo/hi, t0 clock sel1/sel2
// alt control 1: pwm a, cmpa lo, cmpa hi, -, pwm b, cmpb lo, cmpb hi

// ----------------------------------------------------------------------
// pin vector {port b, port a}, request vector positions
// ----------------------------------------------------------------------
`define PC_GROUP_HI 16'hF0C8
`define PC_GROUP_LO 16'h0F00
`define EXT_PIN_IDX 14
`define VEC_EXT 0
`define VEC_PINCHG 1
`define VEC_T1_OVF 2
`define VEC_T0_OVF 3

`endif

// file: src/pin_irq_pkg.sv
// Purpose: shared types of the pin interrupt and mcu control block
// Assumes: used as pin_irq_pkg::name, never imported
// Notes: encodings follow the sense and sleep mode fields
package pin_irq_pkg;
	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_ANY = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} ext_sense_e;

	typedef enum logic [1:0] {
		SLEEP_IDLE = 2'b00,
		SLEEP_ADC_QUIET = 2'b01,
		SLEEP_POWER_DOWN = 2'b10,
		SLEEP_STANDBY = 2'b11
	} sleep_mode_e;
endpackage : pin_irq_pkg

// file: src/pin_sample_if.sv
// Purpose: carries synchronised pin levels and edges between modules
// Assumes: one producer, any number of consumers
// Notes: bits 15..8 are port b, bits 7..0 port a
`timescale 1ns/1ps
`default_nettype none
interface pin_sample_if;
	logic [15:0] level;
	logic [15:0] rise;
	logic [15:0] fall;
	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface : pin_sample_if
`default_nettype wire

// file: src/pin_sync_edge.sv
// Purpose: two-flop synchroniser and edge detector for all port pins
// Assumes: pins are asynchronous to clk_sys
// Notes: edges are held off until the pipeline holds real samples
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [15:0] pins,
	pin_sample_if.producer smp
);
	logic [15:0] meta;
	logic [15:0] stable;
	logic [15:0] prev;
	logic [1:0] fill;
	logic primed;

	// ----------------------------------------------------------------
	// synchroniser; meta is read only by stable
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta <= 16'h0000;
			stable <= 16'h0000;
			prev <= 16'h0000;
			fill <= 2'h0;
		end else begin
			meta <= pins;
			stable <= meta;
			prev <= stable;
			fill <= primed ? fill : fill + 2'h1;
		end
	end

	// reset values are not pin values, so no edge until three samples
	assign primed = (fill == 2'h3);
	assign smp.level = stable;
	assign smp.rise = primed ? (stable & ~prev) : 16'h0000;
	assign smp.fall = primed ? (~stable & prev) : 16'h0000;
endmodule : pin_sync_edge
`default_nettype wire

// file: src/alt_func_mask.sv
// Purpose: per-pin mask of pin change detection by alternate functions
// Assumes: control bits and fuses are steady registers or straps
// Notes: fuse value 0 is programmed, 1 unprogrammed
`timescale 1ns/1ps
`default_nettype none
module alt_func_mask (
	input wire logic [7:0] alt0,
	input wire logic [7:0] alt1,
	input wire logic pll_clock_fuse,
	input wire logic [3:0] clock_source_fuses,
	input wire logic reset_pin_off_fuse,
	input wire logic ext_en,
	input wire logic [1:0] ext_sense,
	output logic [15:0] mask
);
	// wire mode 01 is three-wire; used for three pins
	function automatic logic three_wire(input logic hi, input logic lo);
		return ({hi, lo} == 2'b01);
	endfunction : three_wire

	// inclusive range check on the five clock fuse bits
	function automatic logic fuse_in(input logic [4:0] f, input logic [4:0] lo_v,
		input logic [4:0] hi_v);
		return (f >= lo_v) && (f <= hi_v);
	endfunction : fuse_in

	// ----------------------------------------------------------------
	// decode; each pin is the OR of its enabling combinations
	// ----------------------------------------------------------------
	wire [4:0] fuses = {pll_clock_fuse, clock_source_fuses};
	wire vref_select_bit = alt0[0];
	wire comparator_off = alt0[1];
	wire serial_wiremode_lo = alt0[2];
	wire serial_wiremode_hi = alt0[3];
	wire t0_clk_sel1 = alt0[4];
	wire t0_clk_sel2 = alt0[5];
	wire t1_pwm_chan_a = alt1[0];
	wire t1_cmpa_out_lo = alt1[1];
	wire t1_cmpa_out_hi = alt1[2];
	wire t1_pwm_chan_b = alt1[4];
	wire t1_cmpb_out_lo = alt1[5];
	wire t1_cmpb_out_hi = alt1[6];
	wire tw = three_wire(serial_wiremode_hi, serial_wiremode_lo);
	wire inv_a = ({t1_cmpa_out_hi, t1_cmpa_out_lo, t1_pwm_chan_a} == 3'b011);
	wire inv_b = ({t1_cmpb_out_hi, t1_cmpb_out_lo, t1_pwm_chan_b} == 3'b011);

	assign mask[0] = 1'b0;
	assign mask[1] = 1'b0;
	assign mask[2] = 1'b0;
	assign mask[3] = vref_select_bit;
	assign mask[4] = 1'b0;
	assign mask[5] = 1'b0;
	assign mask[6] = ~comparator_off;
	assign mask[7] = ~comparator_off;
	assign mask[8] = serial_wiremode_hi | tw | inv_a;
	assign mask[9] = tw | t1_cmpa_out_hi | t1_cmpa_out_lo;
	assign mask[10] = serial_wiremode_hi | tw | inv_b;
	assign mask[11] = t1_cmpb_out_hi | t1_cmpb_out_lo;
	assign mask[12] = (fuses == 5'h10) | fuse_in(fuses, 5'h15, 5'h1F);
	assign mask[13] = fuse_in(fuses, 5'h19, 5'h1F);
	assign mask[14] = (ext_en & (ext_sense == 2'b00)) | (t0_clk_sel2 & t0_clk_sel1);
	assign mask[15] = reset_pin_off_fuse;
endmodule : alt_func_mask
`default_nettype wire

// file: src/pin_irq_mcu_ctrl.sv
// Purpose: timer overflow flags, external and pin change interrupts, mcu control
// Assumes: Avalon-MM slave with waitrequest; pins asynchronous, timer events
//   are one-cycle pulses on clk_sys
// Notes: every access answers on the second cycle of the request
//
// What this block does
// - timer one overflow sets its flag
// - vector or delayed write-one clears timer one flag
// - timer one request needs global, enable, flag
// - timer zero flag: set on overflow, cleared by vector or immediate write-one
// - timer zero request needs global, enable, flag
// - reserved bits read zero, ignore writes
// - external pin fires even when driven as output
// - low level requests while pin stays low
// - sense codes: low, any, falling, rising
// - any port b and three port a pins change
// - high group and low group pin assignment
// - disabled group never sets pin change flag
// - other flags set regardless of enable
// - active alternate function masks pin change
// - wire modes or inverted compare mask pb0
// - mask is OR of enabling combinations
// - pin change fires even on output pins
// - one event may raise external and pin change
// - pull-up kill turns off every pull-up
// - sleep only when sleep arm is set
// - sleep mode codes: idle, adc, power-down, standby
// - external flag cleared by vector, write, level mode
`timescale 1ns/1ps
`default_nettype none
`include "pin_irq_params.svh"
module pin_irq_mcu_ctrl (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_a_dir,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_b_dir,
	input wire logic [7:0] port_b_out,
	input wire logic pll_clock_fuse,
	input wire logic [3:0] clock_source_fuses,
	input wire logic reset_pin_off_fuse,
	input wire logic t1_overflow,
	input wire logic t0_overflow,
	input wire logic global_irq_en,
	input wire logic [3:0] irq_ack,
	input wire logic sleep_instr,
	output logic [3:0] irq_req,
	output logic [7:0] port_a_pullup,
	output logic [7:0] port_b_pullup,
	output logic sleep_enter,
	output logic [1:0] sleep_mode
);
	logic [7:0] mcu_general_control;
	logic [7:0] timer_irq_mask;
	logic [7:0] general_irq_mask;
	logic [7:0] alt_ctrl0;
	logic [7:0] alt_ctrl1;
	logic t1_overflow_flag;
	logic t0_overflow_flag;
	logic ext_irq_flag;
	logic pinchg_flag;
	logic t1_clr_pend;
	logic ack_q;
	logic [7:0] rd_value;
	logic [15:0] alt_mask;

	pin_sample_if smp ();

	// ----------------------------------------------------------------
	// pin sampling and alternate function masking
	// ----------------------------------------------------------------
	pin_sync_edge u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pins({port_b_in, port_a_in}),
		.smp(smp.producer)
	);

	alt_func_mask u_mask (
		.alt0(alt_ctrl0),
		.alt1(alt_ctrl1),
		.pll_clock_fuse(pll_clock_fuse),
		.clock_source_fuses(clock_source_fuses),
		.reset_pin_off_fuse(reset_pin_off_fuse),
		.ext_en(general_irq_mask[`BIT_EXT_EN]),
		.ext_sense(mcu_general_control[`BIT_EXT_SENSE_HI:`BIT_EXT_SENSE_LO]),
		.mask(alt_mask)
	);

	// ----------------------------------------------------------------
	// bus decode: one wait cycle, then the answer
	// ----------------------------------------------------------------
	wire [5:0] idx = address[7:2];
	wire [7:0] wdat = writedata[7:0];
	wire hit_mcu = (idx == `IDX_MCU_CTRL);
	wire hit_tflags = (idx == `IDX_TIMER_FLAGS);
	wire hit_tmask = (idx == `IDX_TIMER_MASK);
	wire hit_gflags = (idx == `IDX_GIRQ_FLAGS);
	wire hit_gmask = (idx == `IDX_GIRQ_MASK);
	wire hit_alt0 = (idx == `IDX_ALT_CTRL0);
	wire hit_alt1 = (idx == `IDX_ALT_CTRL1);
	// only byte lane 0 carries register data
	wire wr_go = write & ack_q & byteenable[0];
	wire rd_go = read & ~ack_q;
	assign waitrequest = (read | write) & ~ack_q;

	// write-one-to-clear strobes
	wire t1_w1c = wr_go & hit_tflags & wdat[`BIT_T1_OVF];
	wire t0_w1c = wr_go & hit_tflags & wdat[`BIT_T0_OVF];
	wire ext_w1c = wr_go & hit_gflags & wdat[`BIT_EXT_FLAG];
	wire pc_w1c = wr_go & hit_gflags & wdat[`BIT_PC_FLAG];

	// read mux; unmapped and reserved positions read zero
	always_comb begin
		rd_value = 8'h00;
		if (hit_mcu) begin
			rd_value = mcu_general_control & `MCU_CTRL_WMASK;
		end else if (hit_tflags) begin
			rd_value[`BIT_T1_OVF] = t1_overflow_flag;
			rd_value[`BIT_T0_OVF] = t0_overflow_flag;
		end else if (hit_tmask) begin
			rd_value = timer_irq_mask;
		end else if (hit_gflags) begin
			rd_value[`BIT_EXT_FLAG] = ext_irq_flag;
			rd_value[`BIT_PC_FLAG] = pinchg_flag;
		end else if (hit_gmask) begin
			rd_value = general_irq_mask;
		end else if (hit_alt0) begin
			rd_value = alt_ctrl0;
		end else if (hit_alt1) begin
			rd_value = alt_ctrl1;
		end
	end

	// handshake and read data
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack_q <= (read | write) & ~ack_q;
			if (rd_go) begin
				readdata <= {24'h00_0000, rd_value};
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers; reserved bits are never stored
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mcu_general_control <= `REG_RESET;
			timer_irq_mask <= `REG_RESET;
			general_irq_mask <= `REG_RESET;
			alt_ctrl0 <= `REG_RESET;
			alt_ctrl1 <= `REG_RESET;
		end else if (wr_go) begin
			if (hit_mcu) begin
				mcu_general_control <= wdat & `MCU_CTRL_WMASK;
			end
			if (hit_tmask) begin
				timer_irq_mask <= wdat & `TIMER_MASK_WMASK;
			end
			if (hit_gmask) begin
				general_irq_mask <= wdat & `GIRQ_MASK_WMASK;
			end
			if (hit_alt0) begin
				alt_ctrl0 <= wdat & `ALT_CTRL0_WMASK;
			end
			if (hit_alt1) begin
				alt_ctrl1 <= wdat & `ALT_CTRL1_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// timer overflow flags; a set in the clear cycle wins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			t1_overflow_flag <= 1'b0;
			t0_overflow_flag <= 1'b0;
			t1_clr_pend <= 1'b0;
		end else begin
			// timer one clear waits one synchronisation cycle
			t1_clr_pend <= t1_w1c;
			if (t1_overflow) begin
				t1_overflow_flag <= 1'b1;
			end else if (irq_ack[`VEC_T1_OVF] | t1_clr_pend) begin
				t1_overflow_flag <= 1'b0;
			end
			if (t0_overflow) begin
				t0_overflow_flag <= 1'b1;
			end else if (irq_ack[`VEC_T0_OVF] | t0_w1c) begin
				t0_overflow_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// external interrupt sense decode
	// ----------------------------------------------------------------
	wire [1:0] ext_sense = mcu_general_control[`BIT_EXT_SENSE_HI:`BIT_EXT_SENSE_LO];
	wire ext_lvl = smp.level[`EXT_PIN_IDX];
	wire ext_rise = smp.rise[`EXT_PIN_IDX];
	wire ext_fall = smp.fall[`EXT_PIN_IDX];
	wire level_mode = (ext_sense == pin_irq_pkg::SENSE_LOW);
	// sense changes with the enable set may fire; software avoids that
	wire ext_edge_hit = ((ext_sense == pin_irq_pkg::SENSE_ANY) & (ext_rise | ext_fall))
		| ((ext_sense == pin_irq_pkg::SENSE_FALL) & ext_fall)
		| ((ext_sense == pin_irq_pkg::SENSE_RISE) & ext_rise);

	// ----------------------------------------------------------------
	// pin change detection gated by group enables and masks
	// ----------------------------------------------------------------
	wire pc_hi_en = general_irq_mask[`BIT_PC_GRP_HI];
	wire pc_lo_en = general_irq_mask[`BIT_PC_GRP_LO];
	wire [15:0] grp_en = ({16{pc_hi_en}} & `PC_GROUP_HI) | ({16{pc_lo_en}} & `PC_GROUP_LO);
	wire [15:0] pc_event = (smp.rise | smp.fall) & grp_en & ~alt_mask;
	wire pc_hit = |pc_event;

	// external and pin change flags, independent so one edge sets both
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_irq_flag <= 1'b0;
			pinchg_flag <= 1'b0;
		end else begin
			if (level_mode) begin
				ext_irq_flag <= 1'b0;
			end else if (ext_edge_hit) begin
				ext_irq_flag <= 1'b1;
			end else if (irq_ack[`VEC_EXT] | ext_w1c) begin
				ext_irq_flag <= 1'b0;
			end
			if (pc_hit) begin
				pinchg_flag <= 1'b1;
			end else if (irq_ack[`VEC_PINCHG] | pc_w1c) begin
				pinchg_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// requests to the core
	// ----------------------------------------------------------------
	wire ext_en = general_irq_mask[`BIT_EXT_EN];
	wire ext_src = level_mode ? ~ext_lvl : ext_irq_flag;
	assign irq_req[`VEC_EXT] = global_irq_en & ext_en & ext_src;
	assign irq_req[`VEC_PINCHG] = global_irq_en & (pc_hi_en | pc_lo_en) & pinchg_flag;
	assign irq_req[`VEC_T1_OVF] = global_irq_en & timer_irq_mask[`BIT_T1_OVF]
		& t1_overflow_flag;
	assign irq_req[`VEC_T0_OVF] = global_irq_en & timer_irq_mask[`BIT_T0_OVF]
		& t0_overflow_flag;

	// ----------------------------------------------------------------
	// pull-ups and sleep
	// ----------------------------------------------------------------
	wire pullup_kill = mcu_general_control[`BIT_PULLUP_KILL];
	wire sleep_arm = mcu_general_control[`BIT_SLEEP_ARM];
	// pull-up on where direction is input and output bit is one
	wire [7:0] next_pa_pullup = {8{~pullup_kill}} & ~port_a_dir & port_a_out;
	wire [7:0] next_pb_pullup = {8{~pullup_kill}} & ~port_b_dir & port_b_out;
	assign sleep_mode = mcu_general_control[`BIT_SLEEP_MODE_HI:`BIT_SLEEP_MODE_LO];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_a_pullup <= 8'h00;
			port_b_pullup <= 8'h00;
			sleep_enter <= 1'b0;
		end else begin
			port_a_pullup <= next_pa_pullup;
			port_b_pullup <= next_pb_pullup;
			sleep_enter <= sleep_instr & sleep_arm;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_t1_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		t1_overflow |=> t1_overflow_flag) else $error("t1 overflow flag not set");
	a_t1_clear_late: assert property (@(posedge clk_sys) disable iff (!resetn)
		(t1_w1c && t1_overflow_flag && !t1_overflow && !irq_ack[`VEC_T1_OVF])
		|=> t1_overflow_flag ##1 (!t1_overflow_flag || $past(t1_overflow)))
		else $error("t1 flag clear timing wrong");
	a_t1_request: assert property (@(posedge clk_sys) disable iff (!resetn)
		(t1_overflow && global_irq_en && timer_irq_mask[`BIT_T1_OVF]) ##1 global_irq_en
		|-> irq_req[`VEC_T1_OVF]) else $error("t1 request missing");
	a_t0_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		t0_overflow |=> t0_overflow_flag) else $error("t0 overflow flag not set");
	a_t0_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		(t0_w1c && !t0_overflow) |=> !t0_overflow_flag)
		else $error("t0 flag not cleared");
	a_t0_request: assert property (@(posedge clk_sys) disable iff (!resetn)
		irq_req[`VEC_T0_OVF] |-> $past(t0_overflow) || $past(t0_overflow_flag))
		else $error("t0 request without flag");
	a_no_global: assert property (@(posedge clk_sys) disable iff (!resetn)
		!global_irq_en |-> (irq_req == 4'h0)) else $error("request without global enable");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		(rd_go && hit_mcu) |=> (readdata[7] == 1'b0) && (readdata[2] == 1'b0))
		else $error("reserved bit reads one");
	a_tflags_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
		(rd_go && hit_tflags) |=> (readdata[7] == 1'b0) && (readdata[4:3] == 2'b00)
		&& (readdata[0] == 1'b0)) else $error("reserved flag bit reads one");
	a_level_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		(global_irq_en && ext_en && level_mode && !ext_lvl)[*3] |-> irq_req[`VEC_EXT])
		else $error("level request dropped");
	a_edge_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
		ext_edge_hit |=> ext_irq_flag) else $error("ext edge did not set flag");
	a_fall_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		((ext_sense == pin_irq_pkg::SENSE_FALL) && !ext_fall && !ext_irq_flag)
		|=> !ext_irq_flag) else $error("ext flag set without falling edge");
	a_rise_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		((ext_sense == pin_irq_pkg::SENSE_RISE) && !ext_rise && !ext_irq_flag)
		|=> !ext_irq_flag) else $error("ext flag set without rising edge");
	a_level_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		level_mode |=> !ext_irq_flag) else $error("ext flag set in level mode");
	a_ext_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ext_w1c && !ext_edge_hit) |=> !ext_irq_flag) else $error("ext flag not cleared");
	a_pc_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(pinchg_flag) |-> $past(pc_hit)) else $error("pin change flag without event");
	a_group_block: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!pc_hi_en && !pc_lo_en && !pinchg_flag) |=> !pinchg_flag)
		else $error("pin change flag set with groups off");
	a_pb0_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
		alt_ctrl0[3] |-> alt_mask[8]) else $error("pb0 not masked in wire mode");
	a_pullup_kill: assert property (@(posedge clk_sys) disable iff (!resetn)
		pullup_kill |=> (port_a_pullup == 8'h00) && (port_b_pullup == 8'h00))
		else $error("pull-up left on");
	a_sleep_arm: assert property (@(posedge clk_sys) disable iff (!resetn)
		sleep_enter |-> $past(sleep_instr) && $past(sleep_arm))
		else $error("sleep without arm");
endmodule : pin_irq_mcu_ctrl
`default_nettype wire

// file: testbench/core_model.sv
// Purpose: core stand-in that takes pending vectors when told to
// Assumes: irq_req is a level; ack is a one-cycle pulse
// Notes: takes the lowest pending vector, one at a time
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] irq_req,
	input wire logic service_en,
	output logic [3:0] irq_ack
);
	// one ack pulse per taken vector, then a gap so a flag can fall first
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_ack <= 4'h0;
		end else if (irq_ack != 4'h0) begin
			irq_ack <= 4'h0;
		end else if (service_en) begin
			irq_ack <= irq_req & (~irq_req + 4'h1); // lowest set bit
		end
	end
endmodule : core_model
`default_nettype wire

// file: testbench/pin_irq_mcu_ctrl_tb_top.sv
// Purpose: self-checking bench for the pin interrupt and mcu control block
// Assumes: one wait cycle per bus access; pin edges need three edges to reach flags
// Notes: expected read values are noted in a queue and compared by a watcher
`timescale 1ns/1ps
`default_nettype none
module pin_irq_mcu_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic waitrequest;
	logic [7:0] pa_in = 8'h00, pb_in = 8'hFF, pa_dir = 8'h00, pb_dir = 8'h00;
	logic [7:0] pa_out = 8'h00, pb_out = 8'h00, pa_pu, pb_pu, r;
	logic t1 = 1'b0, t0 = 1'b0, gie = 1'b0, slp = 1'b0, service = 1'b0, s_enter;
	logic [3:0] ack, req;
	logic [1:0] s_mode;
	logic [4:0] fz = 5'h12;
	logic rst_fz = 1'b1;
	logic [31:0] expq[$];
	int num_errors = 0;
	int checks_done = 0;
	always #2.5 clk_sys = ~clk_sys;
	pin_irq_mcu_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
		.readdata(readdata), .waitrequest(waitrequest), .port_a_in(pa_in),
		.port_b_in(pb_in), .port_a_dir(pa_dir), .port_a_out(pa_out), .port_b_dir(pb_dir),
		.port_b_out(pb_out), .pll_clock_fuse(fz[4]), .clock_source_fuses(fz[3:0]),
		.reset_pin_off_fuse(rst_fz), .t1_overflow(t1), .t0_overflow(t0),
		.global_irq_en(gie), .irq_ack(ack), .sleep_instr(slp), .irq_req(req),
		.port_a_pullup(pa_pu), .port_b_pullup(pb_pu), .sleep_enter(s_enter),
		.sleep_mode(s_mode));
	core_model i_core (.clk_sys(clk_sys), .resetn(resetn), .irq_req(req),
		.service_en(service), .irq_ack(ack));
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// waitrequest is taken at the rising edge that it qualifies, as it stood before it
	task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, d};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0) break;
		end
		read <= 1'b0;
		write <= 1'b0;
		if (n == 20) begin
			num_errors++;
			wrap_up();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		expq.push_back({24'h000000, exp});
		bus(a, 1'b0, 8'h00);
	endtask : rd
	task automatic tgl(input logic [7:0] m);
		pb_in <= pb_in ^ m;
		repeat (6) @(posedge clk_sys);
	endtask : tgl
	task automatic sleep_try(input logic [7:0] d, input logic exp);
		bus(8'hD4, 1'b1, d);
		slp <= 1'b1;
		@(posedge clk_sys);
		slp <= 1'b0;
		#1;
		check("sleep_enter", {31'h0, s_enter}, {31'h0, exp});
		check("sleep_mode", {30'h0, s_mode}, {30'h0, d[4:3]});
	endtask : sleep_try
	// read data stand at the accepting edge; the oldest note is the match
	always @(negedge clk_sys) begin
		if (read === 1'b1 && waitrequest === 1'b0)
			check("readdata", readdata, expq.pop_front());
	end
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(38148));
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'hD4, 8'h00);
		rd(8'hE0, 8'h00);
		rd(8'h00, 8'h00);
		r = 8'($urandom);
		bus(8'hD4, 1'b1, r);
		rd(8'hD4, r & 8'h7B);
		pa_dir <= 8'h0F;
		pa_out <= 8'hFF;
		pb_out <= 8'h3C;
		bus(8'hD4, 1'b1, 8'h40);
		repeat (2) @(posedge clk_sys);
		#1;
		check("pullup_a", {16'h0, pa_pu, pb_pu}, 32'h0);
		bus(8'hD4, 1'b1, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1;
		check("pullup_b", {16'h0, pa_pu, pb_pu}, 32'h0000F03C);
		sleep_try(8'h18, 1'b0);
		for (int m = 0; m < 4; m++) sleep_try(8'(8'h20 | (m << 3)), 1'b1);
		repeat ($urandom_range(1, 4)) @(posedge clk_sys);
		t1 <= 1'b1;
		t0 <= 1'b1;
		@(posedge clk_sys);
		t1 <= 1'b0;
		t0 <= 1'b0;
		rd(8'hE0, 8'h06);
		gie <= 1'b1;
		check("req_off", {28'h0, req}, 32'h0);
		bus(8'hE4, 1'b1, 8'h06);
		#1;
		check("req_on", {28'h0, req}, 32'h0000000C);
		bus(8'hE0, 1'b1, 8'h02);
		rd(8'hE0, 8'h04);
		service <= 1'b1;
		repeat (3) @(posedge clk_sys);
		service <= 1'b0;
		rd(8'hE0, 8'h00);
		// write-one on timer one clears only one cycle after the accepting edge
		t1 <= 1'b1;
		@(posedge clk_sys);
		t1 <= 1'b0;
		bus(8'hE0, 1'b1, 8'h04);
		#1;
		check("t1_late", {31'h0, req[2]}, 32'h1);
		@(posedge clk_sys);
		#1;
		check("t1_clear", {31'h0, req[2]}, 32'h0);
		pb_dir <= 8'h40;
		// enable off around every sense change, so the change itself fires nothing
		for (int s = 1; s < 4; s++) begin
			bus(8'hEC, 1'b1, 8'h00);
			bus(8'hD4, 1'b1, 8'(s));
			bus(8'hE8, 1'b1, 8'h40);
			bus(8'hEC, 1'b1, 8'h40);
			tgl(8'h40);
			rd(8'hE8, (s != 3) ? 8'h40 : 8'h00);
			bus(8'hE8, 1'b1, 8'h40);
			tgl(8'h40);
			rd(8'hE8, (s != 2) ? 8'h40 : 8'h00);
		end
		bus(8'hEC, 1'b1, 8'h00);
		bus(8'hD4, 1'b1, 8'h00);
		bus(8'hEC, 1'b1, 8'h40);
		tgl(8'h40);
		check("level_req", {31'h0, req[0]}, 32'h1);
		rd(8'hE8, 8'h00);
		tgl(8'h40);
		check("level_off", {31'h0, req[0]}, 32'h0);
		bus(8'hEC, 1'b1, 8'h10);
		tgl(8'h01);
		rd(8'hE8, 8'h20);
		check("pc_req", {31'h0, req[1]}, 32'h1);
		bus(8'hE8, 1'b1, 8'h20);
		bus(8'hEC, 1'b1, 8'h20);
		tgl(8'h02);
		rd(8'hE8, 8'h00);
		tgl(8'h10);
		rd(8'hE8, 8'h20);
		bus(8'hE8, 1'b1, 8'h20);
		bus(8'hC0, 1'b1, 8'h08);
		bus(8'hEC, 1'b1, 8'h10);
		tgl(8'h01);
		rd(8'hE8, 8'h00);
		bus(8'hC4, 1'b1, 8'h02);
		tgl(8'h02);
		rd(8'hE8, 8'h00);
		bus(8'hEC, 1'b1, 8'h20);
		tgl(8'h80);
		rd(8'hE8, 8'h00);
		fz <= 5'h10;
		tgl(8'h10);
		rd(8'hE8, 8'h00);
		rst_fz <= 1'b0;
		tgl(8'h80);
		rd(8'hE8, 8'h20);
		bus(8'hD4, 1'b1, 8'h01);
		bus(8'hEC, 1'b1, 8'h60);
		bus(8'hE8, 1'b1, 8'h60);
		tgl(8'h40);
		rd(8'hE8, 8'h60);
		wrap_up();
	end
endmodule : pin_irq_mcu_ctrl_tb_top
`default_nettype wire
